// file: verif/rcr_top_tb_top.sv
// Self-checking bench for the rcr_top register block.
// Assumes one clock and read data one cycle after the strobe.
module rcr_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rcr_pkg::*;
   logic        clk = 0, reset = 1, reg_write = 0, reg_read = 0, busy = 0;
   logic        rc = 0, xt = 0, gc = 0, tick = 0, periodic_flag_1, irq;
   logic [3:0]  ev = 0;
   logic [4:0]  event_out;
   logic [7:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, calendar_value, prescaler_count;
   logic [31:0] rv, c0, m, k;
   int          errors = 0, checks = 0, i;
   int          evc = 0;
   logic [7:0]  ra [5];
   rcr_top rcr_top_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy),
      .system_rc_osc(rc), .low_freq_crystal_osc(xt), .generic_clock(gc),
      .overflow_flag(ev[0]), .alarm_flag_0(ev[1]), .alarm_flag_1(ev[2]),
      .periodic_flag_0(ev[3]), .calendar_tick(tick), .prescaler_count(prescaler_count),
      .event_out(event_out), .periodic_flag_1(periodic_flag_1), .irq(irq),
      .calendar_value(calendar_value));
   initial forever #20 clk = ~clk;
   // Counted on the falling edge so a one-cycle pulse is seen settled
   always @(negedge clk) begin
      if (event_out[4]) evc++;
   end
   task summarize;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task rate(input int win, input int e);
      @(posedge clk);
      #1 c0 = prescaler_count;
      repeat (win) @(posedge clk);
      #1 chk(prescaler_count - c0, e);
   endtask
   // Source order: disable while selecting, then enable
   task clock_on(input logic [2:0] s);
      wr(OFS_CLOCK, 32'(s) << SRC_LSB);
      wr(OFS_CLOCK, (32'(s) << SRC_LSB) | 32'h1);
   endtask
   function automatic logic [31:0] cal(int y, int mo, int d, int h, int mi, int s);
      return (y << 26) | (mo << 22) | (d << 17) | (h << 12) | (mi << 6) | s;
   endfunction
   function automatic int src_exp(int s);
      return (s == 2) ? 132 : (s == 4) ? 2 : (s > 4) ? 0 : 64;
   endfunction
   function automatic int tune_exp(int v, int e, int add);
      int n;
      n = ((256 + v - 1) / v) << e;
      return add ? 60 * n / (n - 1) : 60 * n / (n + 1);
   endfunction
   initial begin
      #400000;
      errors++;
      summarize();
   end
   initial begin
      i = $urandom(55590);
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      ra = '{OFS_TAP1, OFS_CLOCK, OFS_TUNER, OFS_EVT_STATE, OFS_CALENDAR};
      foreach (ra[j]) rchk(ra[j], 0);
      rchk(OFS_OPTIONS, 32'h0000_c103);
      wr(OFS_OPTIONS, 32'hffff_ffff);
      rchk(OFS_OPTIONS, 32'h0000_c103);
      rchk(8'h80, 0);
      ra = '{OFS_TAP1, OFS_TUNER, OFS_CALENDAR, OFS_EVT_SET, OFS_EVT_CLR};
      busy <= 1'b1;
      foreach (ra[j]) begin
         wr(ra[j], $urandom);
         rchk(ra[j], 0);
      end
      busy <= 1'b0;
      // Writes made under busy must have left every register at zero
      foreach (ra[j]) rchk(ra[j], 0);
      rchk(OFS_EVT_STATE, 0);
      m = $urandom;
      k = $urandom;
      wr(OFS_EVT_SET, m);
      rchk(OFS_EVT_STATE, m & EVT_VALID);
      wr(OFS_EVT_CLR, k);
      m = m & ~k & EVT_VALID;
      rchk(OFS_EVT_STATE, m);
      rchk(OFS_EVT_CLR, 0);
      repeat (8) begin
         @(posedge clk);
         ev <= 4'($urandom);
         @(posedge clk);
         k = 32'(ev & {m[EVT_PERIODIC_FLAG_0], m[EVT_ALARM_FLAG_1], m[EVT_ALARM_FLAG_0], m[EVT_OVF]});
         ev <= 4'h0;
         #1 chk(32'(event_out[3:0]), k);
      end
      i = $urandom_range(58);
      for (int j = 0; j < 4; j++) begin
         m = j == 0 ? cal(0, 2, 28, 23, 59, 59) : j == 1 ? cal(1, 2, 28, 23, 59, 59)
           : j == 2 ? cal(5, 12, 31, 23, 59, 59) : cal(7, 4, 30, 9, i, 59);
         k = j == 0 ? cal(0, 2, 29, 0, 0, 0) : j == 1 ? cal(1, 3, 1, 0, 0, 0)
           : j == 2 ? cal(6, 1, 1, 0, 0, 0) : cal(7, 4, 30, 9, i + 1, 0);
         wr(OFS_CALENDAR, m);
         rchk(OFS_CALENDAR, m);
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         @(posedge clk);
         #1 chk(calendar_value, k);
      end
      wr(OFS_EVT_SET, 32'h0002_0000);
      wr(OFS_IRQ_MASK, 32'h0002_0000);
      wr(OFS_TAP1, 32'h3);
      rchk(OFS_TAP1, 32'h3);
      clock_on(3'h2);
      repeat (20) @(posedge clk);
      wr(OFS_CLOCK, 32'h200);
      repeat (4) @(posedge clk);
      #1 chk({periodic_flag_1, irq}, 2'b11);
      // 22 prescaler counts pass bit 3 rising exactly once
      chk(evc, 1);
      rate(20, 0);
      wr(OFS_IRQ_STATUS, 32'h0002_0000);
      repeat (2) @(posedge clk);
      #1 chk({periodic_flag_1, irq}, 2'b00);
      for (i = 0; i < 8; i++) begin
         clock_on(3'(i));
         repeat (3) @(posedge clk);
         #1 c0 = prescaler_count;
         repeat (64) begin
            @(posedge clk);
            {rc, xt, gc} <= 3'b111;
            @(posedge clk);
            {rc, xt, gc} <= 3'b000;
         end
         repeat (4) @(posedge clk);
         #1 chk(prescaler_count - c0, src_exp(i));
      end
      clock_on(3'h2);
      rate(60, 60);
      for (i = 0; i < 8; i++) begin
         m = ((i[2] ? 32'd255 : 32'd128) << 8) | (32'(i[0]) << 5) | 32'(i[1]);
         wr(OFS_TUNER, m);
         rchk(OFS_TUNER, m);
         rate(60, tune_exp(m[15:8], i[1], i[0]));
      end
      summarize();
   end
endmodule

// file: verilog/rcr_cal_if.sv
// Link between the register front end and the calendar stepper.
// Assumes both ends run on the same clock.
interface rcr_cal_if;
   logic        tick;
   logic        load;
   logic [31:0] load_value;
   logic [31:0] value;

   modport owner (input tick, input load, input load_value, output value);
   modport user  (output tick, output load, output load_value, input value);
endinterface

// file: verilog/rcr_calendar.sv
// Calendar value register and its one-second stepper.
// Assumes a one-cycle tick per second and legal values loaded by software.
module rcr_calendar
   import rcr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register side
   rcr_cal_if.owner cal
);
   logic [31:0] cal_q;
   logic [31:0] cal_d;
   logic [5:0]  year;
   logic [3:0]  month;
   logic [4:0]  day;
   logic [4:0]  hour;
   logic [5:0]  minute;
   logic [5:0]  second;
   logic [4:0]  last_day;

   assign {year, month, day, hour, minute, second} = cal_q;
   assign cal.value = cal_q;

   always_comb begin
      unique case (month)
         MONTH_FEB: last_day = (year[1:0] == 2'b00) ? 5'h1d : 5'h1c;
         4'h4, 4'h6, 4'h9, 4'hb: last_day = 5'h1e;
         default: last_day = 5'h1f;
      endcase
   end

   always_comb begin
      cal_d = cal_q;
      if (second != MINSEC_MAX) begin
         cal_d[CAL_SEC_LSB +: 6] = second + 6'h1;
      end else begin
         cal_d[CAL_SEC_LSB +: 6] = 6'h0;
         if (minute != MINSEC_MAX) begin
            cal_d[CAL_MIN_LSB +: 6] = minute + 6'h1;
         end else begin
            cal_d[CAL_MIN_LSB +: 6] = 6'h0;
            if (hour != HOUR_MAX) begin
               cal_d[CAL_HOUR_LSB +: 5] = hour + 5'h1;
            end else begin
               cal_d[CAL_HOUR_LSB +: 5] = 5'h0;
               if (day < last_day) begin
                  cal_d[CAL_DAY_LSB +: 5] = day + 5'h1;
               end else begin
                  cal_d[CAL_DAY_LSB +: 5] = DAY_FIRST;
                  if (month < MONTH_MAX) begin
                     cal_d[CAL_MONTH_LSB +: 4] = month + 4'h1;
                  end else begin
                     cal_d[CAL_MONTH_LSB +: 4] = MONTH_FIRST;
                     cal_d[CAL_YEAR_LSB +: 6] = year + 6'h1;
                  end
               end
            end
         end
      end
   end

   // A load in the same cycle as a tick wins, software owns the value
   always_ff @(posedge clk) begin
      if (reset) begin
         cal_q <= RST_ZERO;
      end else if (cal.load) begin
         cal_q <= cal.load_value;
      end else if (cal.tick) begin
         cal_q <= cal_d;
      end
   end

   property p_hour_wrap;
      @(posedge clk) disable iff (reset)
      cal.tick && !cal.load && second == MINSEC_MAX && minute == MINSEC_MAX
         && hour == HOUR_MAX |=> hour == 5'h0 && day != $past(day);
   endproperty
   a_hour_wrap: assert property (p_hour_wrap) else $error("hour did not wrap");

   property p_leap;
      @(posedge clk) disable iff (reset)
      cal.tick && !cal.load && cal_d[CAL_HOUR_LSB +: 5] == 5'h0 && month == MONTH_FEB
         && day == 5'h1c && hour == HOUR_MAX |=> day == ((year[1:0] == 2'b00) ? 5'h1d : 5'h01);
   endproperty
   a_leap: assert property (p_leap) else $error("leap day wrong");

   property p_minsec;
      @(posedge clk) disable iff (reset)
      cal.tick && !cal.load && second <= MINSEC_MAX && minute <= MINSEC_MAX
         |=> second <= MINSEC_MAX && minute <= MINSEC_MAX;
   endproperty
   a_minsec: assert property (p_minsec) else $error("minute or second out of range");

   c_year_roll: cover property (@(posedge clk) cal.tick && month == MONTH_MAX && day == 5'h1f
      && hour == HOUR_MAX && minute == MINSEC_MAX && second == MINSEC_MAX);
endmodule

// file: verilog/rcr_pkg.sv
// Constants, field layout and types of the prescaler, tuner, event and calendar registers.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
// What this block does
// - Busy flag blocks tap, tuner, event set/clear and calendar writes, their reads return zero
// - Chosen prescaler tap rising sets periodic flag
// - Source select picks prescaler clock source
// - Clock enable gates the prescaler clock
// - Tuner value zero leaves frequency alone
// - Add clear: drop one clock per period
// - Add set: insert one clock per period
// - Event set writes of one set mask
// - Event clear writes of one clear mask
// - Mask resets zero and gates event outputs
// - Leap year when year low bits zero
// - Month 1 to 12, day from 1
// - Hour 0 to 23, wraps into day
// - Minute and second 0 to 59, roll over
// - Options bit 0 reports tuner presence
// - Fixed exponent discards exponent writes
// - Options register is read only
package rcr_pkg;
   localparam logic [7:0]  OFS_TAP1       = 8'h34;
   localparam logic [7:0]  OFS_CLOCK      = 8'h40;
   localparam logic [7:0]  OFS_TUNER      = 8'h44;
   localparam logic [7:0]  OFS_EVT_SET    = 8'h48;
   localparam logic [7:0]  OFS_EVT_CLR    = 8'h4c;
   localparam logic [7:0]  OFS_EVT_STATE  = 8'h50;
   localparam logic [7:0]  OFS_CALENDAR   = 8'h54;
   localparam logic [7:0]  OFS_IRQ_STATUS = 8'h58;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h5c;
   localparam logic [7:0]  OFS_OPTIONS    = 8'hf0;
   localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
   localparam int          CLK_ON_BIT     = 0;
   localparam int          SRC_LSB        = 8;
   localparam int          TUNE_ADD_BIT   = 5;
   localparam int          TUNE_VAL_LSB   = 8;
   localparam logic [15:0] TUNE_FULL      = 16'h0100;
   localparam logic [31:0] EVT_VALID      = 32'h0003_0301;
   localparam int          EVT_OVF        = 0;
   localparam int          EVT_ALARM_FLAG_0     = 8;
   localparam int          EVT_ALARM_FLAG_1     = 9;
   localparam int          EVT_PERIODIC_FLAG_0       = 16;
   localparam int          EVT_PERIODIC_FLAG_1       = 17;
   localparam int          KHZ_DIV_W      = 5;
   localparam int          CAL_YEAR_LSB   = 26;
   localparam int          CAL_MONTH_LSB  = 22;
   localparam int          CAL_DAY_LSB    = 17;
   localparam int          CAL_HOUR_LSB   = 12;
   localparam int          CAL_MIN_LSB    = 6;
   localparam int          CAL_SEC_LSB    = 0;
   localparam logic [4:0]  HOUR_MAX       = 5'h17;
   localparam logic [5:0]  MINSEC_MAX     = 6'h3b;
   localparam logic [3:0]  MONTH_MAX      = 4'hc;
   localparam logic [3:0]  MONTH_FEB      = 4'h2;
   localparam logic [4:0]  DAY_FIRST      = 5'h01;
   localparam logic [3:0]  MONTH_FIRST    = 4'h1;
   localparam int          OPT_DT         = 0;
   localparam int          OPT_EXPWA      = 1;
   localparam int          OPT_EXPVAL_LSB = 2;
   localparam int          OPT_ALARM_COMPARATOR_COUNT_LSB  = 8;
   localparam int          OPT_PERIODIC_COMPARATOR_COUNT     = 12;
   localparam int          OPT_TAP_WRITABLE_0     = 14;
   localparam int          OPT_TAP_WRITABLE_1     = 15;
   localparam int          OPT_PERIODIC_FLAG_0_LSB   = 16;
   localparam int          OPT_PERIODIC_FLAG_1_LSB   = 24;

   typedef enum logic [2:0] {
      SRC_RC   = 3'b000,
      SRC_XTAL = 3'b001,
      SRC_PB   = 3'b010,
      SRC_GEN  = 3'b011,
      SRC_KHZ  = 3'b100
   } rcr_src_type;
endpackage

// file: verilog/rcr_top.sv
// Prescaler clock select, frequency tuner, event mask, calendar and options registers.
// Assumes clock sources are levels synchronous to clk and busy comes from the counter side.
//
// Local design decision: the plain strobed port.
module rcr_top
   import rcr_pkg::*;
#(
   parameter int unsigned PRESC_W            = 32,
   parameter int unsigned TUNE_W             = 40,
   parameter bit          TUNER_PRESENT      = 1'b1,
   parameter bit          TUNER_EXP_WRITABLE = 1'b1,
   parameter logic [4:0]  TUNER_EXP_CONST    = 5'h00,
   parameter bit          TAP_WRITABLE_0     = 1'b1,
   parameter bit          TAP_WRITABLE_1     = 1'b1,
   parameter logic [4:0]  TAP_CONST_0        = 5'h00,
   parameter logic [4:0]  TAP_CONST_1        = 5'h00,
   parameter bit          PERIODIC_COUNT     = 1'b0,
   parameter logic [1:0]  ALARM_COUNT        = 2'h1
)(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_write,
   input  wire logic               reg_read,
   output logic [31:0]             reg_rdata,
   // Counter side status
   input  wire logic               busy,
   // Prescaler clock sources
   input  wire logic               system_rc_osc,
   input  wire logic               low_freq_crystal_osc,
   input  wire logic               generic_clock,
   // Event sources and calendar tick
   input  wire logic               overflow_flag,
   input  wire logic               alarm_flag_0,
   input  wire logic               alarm_flag_1,
   input  wire logic               periodic_flag_0,
   input  wire logic               calendar_tick,
   // Results
   output logic [PRESC_W-1:0]      prescaler_count,
   output logic [4:0]              event_out,
   output logic                    periodic_flag_1,
   output logic                    irq,
   output logic [31:0]             calendar_value
);
   // Registers hidden behind busy
   function automatic logic blocked(input logic [7:0] a);
      return a == OFS_TAP1 || a == OFS_TUNER || a == OFS_EVT_SET
          || a == OFS_EVT_CLR || a == OFS_CALENDAR;
   endfunction

   function automatic logic [8:0] ceil256(input logic [7:0] v);
      logic [15:0] q;
      q = (v == 8'h0) ? 16'h0 : (TUNE_FULL + 16'(v) - 16'h1) / 16'(v);
      return q[8:0];
   endfunction

   function automatic int evt_pos(input int i);
      case (i)
         0:       return EVT_OVF;
         1:       return EVT_ALARM_FLAG_0;
         2:       return EVT_ALARM_FLAG_1;
         3:       return EVT_PERIODIC_FLAG_0;
         default: return EVT_PERIODIC_FLAG_1;
      endcase
   endfunction

   logic [4:0]          tap1_q;
   logic [2:0]          src_q;
   logic                cen_q;
   logic [7:0]          tune_val_q;
   logic                tune_add_q;
   logic [4:0]          tune_exp_q;
   logic [31:0]         evm_q;
   logic [31:0]         status_q;
   logic [31:0]         irq_mask_q;
   logic [31:0]         rdata_q;
   logic [PRESC_W-1:0]  presc_q;
   logic [TUNE_W-1:0]   tcnt_q;
   logic [KHZ_DIV_W-1:0] khz_div_q;
   logic                xtal_prev_q;
   logic                src_prev_q;
   logic                tap1_prev_q;
   logic                irq_q;
   logic [4:0]          event_q;
   logic                wr_ok;
   logic                rd_blank;
   logic                kilohertz_clock;
   logic                src_lvl;
   logic                src_edge;
   logic                presc_tick;
   logic [4:0]          exp_eff;
   logic [4:0]          tap1_eff;
   logic [TUNE_W-1:0]   tune_n;
   logic                tune_on;
   logic                tap1_lvl;
   logic                periodic_flag_1_rise;
   logic [4:0]          evt_src;
   logic [31:0]         options;
   logic [31:0]         rd_val;

   rcr_cal_if cal_link ();

   rcr_calendar rcr_calendar_i (
      .clk   (clk),
      .reset (reset),
      .cal   (cal_link)
   );

   assign wr_ok    = reg_write && !(busy && blocked(reg_addr));
   assign rd_blank = busy && blocked(reg_addr);

   assign cal_link.tick       = calendar_tick;
   assign cal_link.load       = wr_ok && reg_addr == OFS_CALENDAR;
   assign cal_link.load_value = reg_wdata;

   // Register writes
   always_ff @(posedge clk) begin
      if (reset) begin
         tap1_q <= 5'h0;
      end else if (wr_ok && reg_addr == OFS_TAP1 && TAP_WRITABLE_1) begin
         tap1_q <= reg_wdata[4:0];
      end
   end

   // Software disables first, then changes source, then enables
   always_ff @(posedge clk) begin
      if (reset) begin
         src_q <= 3'h0;
         cen_q <= 1'b0;
      end else if (wr_ok && reg_addr == OFS_CLOCK) begin
         src_q <= reg_wdata[SRC_LSB +: 3];
         cen_q <= reg_wdata[CLK_ON_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tune_val_q <= 8'h0;
         tune_add_q <= 1'b0;
         tune_exp_q <= 5'h0;
      end else if (wr_ok && reg_addr == OFS_TUNER && TUNER_PRESENT) begin
         tune_val_q <= reg_wdata[TUNE_VAL_LSB +: 8];
         tune_add_q <= reg_wdata[TUNE_ADD_BIT];
         if (TUNER_EXP_WRITABLE) begin
            tune_exp_q <= reg_wdata[4:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         evm_q <= RST_ZERO;
      end else if (wr_ok && reg_addr == OFS_EVT_SET) begin
         evm_q <= evm_q | (reg_wdata & EVT_VALID);
      end else if (wr_ok && reg_addr == OFS_EVT_CLR) begin
         evm_q <= evm_q & ~(reg_wdata & EVT_VALID);
      end
   end

   // Prescaler clock source
   always_ff @(posedge clk) begin
      if (reset) begin
         xtal_prev_q <= 1'b0;
         khz_div_q   <= '0;
      end else begin
         xtal_prev_q <= low_freq_crystal_osc;
         if (low_freq_crystal_osc && !xtal_prev_q) begin
            khz_div_q <= khz_div_q + 1'b1;
         end
      end
   end

   assign kilohertz_clock = khz_div_q[KHZ_DIV_W-1];

   always_comb begin
      unique case (rcr_src_type'(src_q))
         SRC_RC:   src_lvl = system_rc_osc;
         SRC_XTAL: src_lvl = low_freq_crystal_osc;
         SRC_PB:   src_lvl = 1'b1;
         SRC_GEN:  src_lvl = generic_clock;
         SRC_KHZ:  src_lvl = kilohertz_clock;
         default:  src_lvl = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_lvl;
      end
   end

   // Bus clock source counts every cycle
   assign src_edge   = (src_q == SRC_PB) ? 1'b1 : (src_lvl && !src_prev_q);
   assign presc_tick = cen_q && src_edge;

   // Tuner
   assign exp_eff = TUNER_EXP_WRITABLE ? tune_exp_q : TUNER_EXP_CONST;
   assign tune_n  = TUNE_W'(ceil256(tune_val_q)) << exp_eff;
   assign tune_on = TUNER_PRESENT && tune_val_q != 8'h0;

   // Counter as wide as tune_n needs; 256 shifted by the largest exponent still fits the width
   // Bounds compare with >= so a tuner rewrite that shrinks N cannot strand the count
   always_ff @(posedge clk) begin
      if (reset) begin
         presc_q <= '0;
         tcnt_q  <= '0;
      end else if (presc_tick) begin
         if (!tune_on) begin
            presc_q <= presc_q + 1'b1;
            tcnt_q  <= '0;
         end else if (!tune_add_q) begin
            if (tcnt_q >= tune_n) begin
               tcnt_q <= '0;
            end else begin
               presc_q <= presc_q + 1'b1;
               tcnt_q  <= tcnt_q + 1'b1;
            end
         end else if (tcnt_q >= tune_n - TUNE_W'(2)) begin
            presc_q <= presc_q + PRESC_W'(2);
            tcnt_q  <= '0;
         end else begin
            presc_q <= presc_q + 1'b1;
            tcnt_q  <= tcnt_q + 1'b1;
         end
      end
   end

   assign prescaler_count = presc_q;

   // Periodic tap
   assign tap1_eff  = TAP_WRITABLE_1 ? tap1_q : TAP_CONST_1;
   assign tap1_lvl  = presc_q[tap1_eff];
   assign periodic_flag_1_rise = tap1_lvl && !tap1_prev_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         tap1_prev_q <= 1'b0;
      end else begin
         tap1_prev_q <= tap1_lvl;
      end
   end

   // Status and interrupt; a set in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (reset) begin
         status_q <= RST_ZERO;
      end else begin
         if (reg_write && reg_addr == OFS_IRQ_STATUS) begin
            status_q[EVT_PERIODIC_FLAG_1] <= (status_q[EVT_PERIODIC_FLAG_1] && !reg_wdata[EVT_PERIODIC_FLAG_1]) || periodic_flag_1_rise;
         end else if (periodic_flag_1_rise) begin
            status_q[EVT_PERIODIC_FLAG_1] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_mask_q <= RST_ZERO;
      end else if (reg_write && reg_addr == OFS_IRQ_MASK) begin
         irq_mask_q <= reg_wdata & (32'h1 << EVT_PERIODIC_FLAG_1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & irq_mask_q);
      end
   end

   assign periodic_flag_1 = status_q[EVT_PERIODIC_FLAG_1];
   assign irq             = irq_q;

   // Peripheral events
   assign evt_src = {periodic_flag_1_rise, periodic_flag_0, alarm_flag_1, alarm_flag_0, overflow_flag};

   for (genvar i = 0; i < 5; i++) begin : g_evt
      always_ff @(posedge clk) begin
         if (reset) begin
            event_q[i] <= 1'b0;
         end else begin
            event_q[i] <= evt_src[i] && evm_q[evt_pos(i)];
         end
      end
   end

   assign event_out = event_q;

   // Read side
   always_comb begin
      options                          = RST_ZERO;
      options[OPT_DT]                  = TUNER_PRESENT;
      options[OPT_EXPWA]               = TUNER_EXP_WRITABLE;
      options[OPT_EXPVAL_LSB +: 5]     = TUNER_EXP_CONST;
      options[OPT_ALARM_COMPARATOR_COUNT_LSB +: 2]      = ALARM_COUNT;
      options[OPT_PERIODIC_COMPARATOR_COUNT]              = PERIODIC_COUNT;
      options[OPT_TAP_WRITABLE_0]              = TAP_WRITABLE_0;
      options[OPT_TAP_WRITABLE_1]              = TAP_WRITABLE_1;
      options[OPT_PERIODIC_FLAG_0_LSB +: 5]       = TAP_CONST_0;
      options[OPT_PERIODIC_FLAG_1_LSB +: 5]       = TAP_CONST_1;
   end

   always_comb begin
      rd_val = RST_ZERO;
      unique case (reg_addr)
         OFS_TAP1:       rd_val = {27'h0, tap1_eff};
         OFS_CLOCK:      rd_val = {21'h0, src_q, 7'h0, cen_q};
         OFS_TUNER:      rd_val = TUNER_PRESENT ? {16'h0, tune_val_q, 2'h0, tune_add_q, exp_eff}
                                                : RST_ZERO;
         OFS_EVT_STATE:  rd_val = evm_q;
         OFS_CALENDAR:   rd_val = cal_link.value;
         OFS_IRQ_STATUS: rd_val = status_q;
         OFS_IRQ_MASK:   rd_val = irq_mask_q;
         OFS_OPTIONS:    rd_val = options;
         default:        rd_val = RST_ZERO;
      endcase
      if (rd_blank) begin
         rd_val = RST_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= RST_ZERO;
      end else begin
         rdata_q <= reg_read ? rd_val : RST_ZERO;
      end
   end

   assign reg_rdata      = rdata_q;
   assign calendar_value = cal_link.value;

   // Checks
   property p_busy_read;
      @(posedge clk) disable iff (reset)
      reg_read && busy && blocked(reg_addr) |=> reg_rdata == RST_ZERO;
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy read not zero");

   property p_busy_write;
      @(posedge clk) disable iff (reset)
      reg_write && busy && reg_addr == OFS_TUNER |=> $stable(tune_val_q) && $stable(tune_add_q);
   endproperty
   a_busy_write: assert property (p_busy_write) else $error("busy write taken");

   property p_periodic_flag_1_set;
      @(posedge clk) disable iff (reset)
      $rose(presc_q[tap1_eff]) && $stable(tap1_eff) |-> ##1 periodic_flag_1 ##1 irq == irq_mask_q[EVT_PERIODIC_FLAG_1];
   endproperty
   a_periodic_flag_1_set: assert property (p_periodic_flag_1_set) else $error("periodic flag not set");

   property p_pb_source;
      @(posedge clk) disable iff (reset)
      cen_q && src_q == SRC_PB && !tune_on |=> presc_q == $past(presc_q) + 1'b1;
   endproperty
   a_pb_source: assert property (p_pb_source) else $error("bus clock source not counting");

   property p_clock_off;
      @(posedge clk) disable iff (reset)
      !cen_q [*2] |-> $stable(presc_q);
   endproperty
   a_clock_off: assert property (p_clock_off) else $error("prescaler ran while off");

   property p_tuner_drop;
      @(posedge clk) disable iff (reset)
      presc_tick && tune_on && !tune_add_q && tcnt_q == tune_n |=> $stable(presc_q) && tcnt_q == '0;
   endproperty
   a_tuner_drop: assert property (p_tuner_drop) else $error("no clock dropped");

   property p_tuner_add;
      @(posedge clk) disable iff (reset)
      presc_tick && tune_on && tune_add_q && tcnt_q == tune_n - TUNE_W'(2)
         |=> presc_q == $past(presc_q) + PRESC_W'(2);
   endproperty
   a_tuner_add: assert property (p_tuner_add) else $error("no clock added");

   property p_evt_set;
      @(posedge clk) disable iff (reset)
      reg_write && !busy && reg_addr == OFS_EVT_SET
         |=> (evm_q & $past(reg_wdata) & EVT_VALID) == ($past(reg_wdata) & EVT_VALID);
   endproperty
   a_evt_set: assert property (p_evt_set) else $error("event mask not set");

   property p_evt_clr;
      @(posedge clk) disable iff (reset)
      reg_write && !busy && reg_addr == OFS_EVT_CLR |=> (evm_q & $past(reg_wdata)) == RST_ZERO
         && (evm_q | $past(reg_wdata)) == ($past(evm_q) | $past(reg_wdata));
   endproperty
   a_evt_clr: assert property (p_evt_clr) else $error("event mask not cleared");

   property p_evt_gate;
      @(posedge clk) disable iff (reset)
      overflow_flag ##1 1'b1 |-> event_out[0] == $past(evm_q[EVT_OVF]);
   endproperty
   a_evt_gate: assert property (p_evt_gate) else $error("event not gated by mask");

   property p_options;
      @(posedge clk) disable iff (reset)
      reg_read && reg_addr == OFS_OPTIONS |=> reg_rdata[OPT_DT] == TUNER_PRESENT
         && reg_rdata == options;
   endproperty
   a_options: assert property (p_options) else $error("options read wrong");

   c_busy_read: cover property (@(posedge clk) reg_read && busy && reg_addr == OFS_CALENDAR);
   c_drop: cover property (@(posedge clk) presc_tick && tune_on && !tune_add_q && tcnt_q == tune_n);
   c_irq: cover property (@(posedge clk) $rose(irq));
   c_event: cover property (@(posedge clk) event_out[4]);
endmodule
